// File: bridge_pkg.sv
/*
  shared constants and carrier types for the core-side address decoder.
  assumes a single 200 MHz clock domain and 32-bit physical addresses.
*/
`default_nettype none
package bridge_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [31:0] ROM_LO = 32'h1800_0000;
  localparam logic [31:0] ROM_HI = 32'h1FFF_FFFF;
  localparam logic [31:0] BCR_LO = 32'h0A00_0000;
  localparam logic [31:0] BCR_HI = 32'h0A00_0014;
  localparam logic [31:0] IRQ_A0 = 32'h0A00_0080;
  localparam logic [31:0] IRQ_A1 = 32'h0A00_008C;
  localparam logic [31:0] IRQ_A2 = 32'h0A00_0098;
  localparam logic [31:0] IRQ_A3 = 32'h0A00_009A;
  localparam logic [31:0] IRQ_A4 = 32'h0A00_0200;
  localparam logic [31:0] IRQ_A5 = 32'h0A00_0206;
  localparam logic [31:0] DRAM_LO = 32'h0000_0000;
  localparam logic [31:0] DRAM_HI = 32'h03FF_FFFF;
  localparam logic [31:0] MEMC_LO = 32'h0A00_0300;
  localparam logic [31:0] MEMC_HI = 32'h0A00_03FF;
  localparam logic [31:0] DMA1_LO = 32'h0A00_0020;
  localparam logic [31:0] DMA1_HI = 32'h0A00_0048;
  localparam logic [31:0] DMA2_LO = 32'h0A00_0600;
  localparam logic [31:0] DMA2_HI = 32'h0A00_06FF;
  localparam logic [31:0] DISP_LO = 32'h0A00_0400;
  localparam logic [31:0] DISP_HI = 32'h0A00_05FF;
  localparam logic [31:0] ISAIO_LO = 32'h1400_0000;
  localparam logic [31:0] ISAIO_HI = 32'h17FF_FFFF;
  localparam logic [31:0] ISAMEM_LO = 32'h1000_0000;
  localparam logic [31:0] ISAMEM_HI = 32'h13FF_FFFF;
  localparam logic [31:0] ISAW1_LO = 32'h0B00_0000;
  localparam logic [31:0] ISAW1_HI = 32'h0BFF_FFFF;
  localparam logic [31:0] ISAW2_LO = 32'h0C00_0000;
  localparam logic [31:0] ISAW2_HI = 32'h0CFF_FFFF;

  // ****************************************
  // register offsets, masks and reset values
  // ****************************************
  localparam logic [31:0] ROM_BUS_CONTROL_ADDR = 32'h0A00_0000;
  localparam logic [31:0] PERIPHERAL_CLOCK_GATE_ADDR = 32'h0A00_0004;
  localparam logic [31:0] ROM_ACCESS_TIMING_ADDR = 32'h0A00_000C;
  localparam logic [31:0] REFRESH_CONTROL_ADDR = 32'h0A00_0010;
  localparam logic [31:0] SILICON_REVISION_ADDR = 32'h0A00_0014;
  localparam logic [31:0] CLOCK_SPEED_REPORT_ADDR = 32'h0A00_0018;
  localparam logic [15:0] ROM_BUS_CONTROL_MASK = 16'hC017;
  localparam logic [15:0] ROM_BUS_CONTROL_RST = 16'h8000;
  localparam logic [15:0] CLOCK_GATE_MASK = 16'h007F;
  localparam logic [15:0] CLOCK_GATE_RST = 16'h0000;
  localparam logic [15:0] ROM_TIMING_MASK = 16'h700F;
  localparam logic [15:0] ROM_TIMING_RST = 16'h700F;
  localparam logic [15:0] REFRESH_RST = 16'h0000;
  localparam int CLK_GATE_W = 6;
  localparam int CLK_GATE_LSB = 1;

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [3:0] {
    TGT_NONE, TGT_ROM, TGT_BUS_CTRL, TGT_IRQ, TGT_MEMC, TGT_DMA,
    TGT_DISPLAY, TGT_ISA, TGT_BUS
  } target_e;

  // module selects driven onto the internal peripheral bus
  typedef struct packed {
    logic rom;
    logic bus_ctrl;
    logic irq;
    logic memc;
    logic dma;
    logic display;
    logic isa;
  } sel_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [15:0] wdata;
  } req_s;

endpackage : bridge_pkg
`default_nettype wire

// File: host_bridge_address_decoder.sv
/*
  core-side address decoder and request router with its bus control registers.
  assumes requests arrive synchronous to clock_i, one per cycle at most, and
  that hibernate_i is a synchronous level from power management.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bridge_address_decoder
  import bridge_pkg::*;
#(
  parameter logic [15:0] REVISION = 16'h0001, // arbitrary value
  parameter logic [15:0] CLOCK_SPEED = 16'h0000 // arbitrary value
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hibernate_i,
  // core request
  input wire req_s core_req_i,
  output logic core_ack_o,
  output logic [15:0] core_rdata_o,
  output var target_e core_target_o,
  // other bus masters
  input wire logic ext_valid_i,
  input wire logic [31:0] ext_addr_i,
  // internal peripheral bus
  output var sel_s sel_o,
  output logic bus_start_o,
  output logic [31:0] bus_addr_o,
  output logic bus_write_o,
  output logic [15:0] bus_wdata_o,
  // control outputs from registers
  output logic [CLK_GATE_W-1:0] clk_enable_o,
  output logic [15:0] rom_control_o,
  output logic [15:0] rom_timing_o,
  output logic [15:0] refresh_control_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
    target_e target;
    sel_s sel;
    logic start;
    logic [31:0] addr;
    logic write;
    logic [15:0] wdata;
    logic [15:0] rom_ctl;
    logic [15:0] clk_gate;
    logic [15:0] rom_tim;
    logic [15:0] refresh;
  } state_s;

  state_s q, d;
  // release stages live apart from the state copy so each register has one writer
  logic [1:0] rst_sync_q;
  logic [1:0] rst_sync_d;
  logic srst_n;
  assign rst_sync_d = {rst_sync_q[0], 1'b1};
  assign srst_n = rst_sync_q[1];

  // ****************************************
  // decode
  // ****************************************
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // ****************************************
  // range hits
  // ****************************************
  // one flag per window; the chain below folds them into a single target
  typedef struct packed {
    logic rom;
    logic bus_ctrl;
    logic irq;
    logic dram;
    logic memc_regs;
    logic dma_one;
    logic dma_two;
    logic display;
    logic isa_io;
    logic isa_mem;
    logic isa_win_one;
    logic isa_win_two;
  } hit_s;

  // full-width compares: a hit needs the whole address, no aliasing
  function automatic hit_s hits_of(input logic [31:0] a);
    hit_s h;
    h.rom = in_rng(a, ROM_LO, ROM_HI);
    h.bus_ctrl = in_rng(a, BCR_LO, BCR_HI);
    h.irq = (a == IRQ_A0) || (a == IRQ_A1) || (a == IRQ_A2) ||
            (a == IRQ_A3) || (a == IRQ_A4) || (a == IRQ_A5);
    h.dram = in_rng(a, DRAM_LO, DRAM_HI);
    h.memc_regs = in_rng(a, MEMC_LO, MEMC_HI);
    h.dma_one = in_rng(a, DMA1_LO, DMA1_HI);
    h.dma_two = in_rng(a, DMA2_LO, DMA2_HI);
    h.display = in_rng(a, DISP_LO, DISP_HI);
    h.isa_io = in_rng(a, ISAIO_LO, ISAIO_HI);
    h.isa_mem = in_rng(a, ISAMEM_LO, ISAMEM_HI);
    h.isa_win_one = in_rng(a, ISAW1_LO, ISAW1_HI);
    h.isa_win_two = in_rng(a, ISAW2_LO, ISAW2_HI);
    return h;
  endfunction

  // single priority chain keeps the result exclusive
  function automatic target_e decode(input hit_s h);
    if (h.rom) begin
      decode = TGT_ROM;
    end else if (h.bus_ctrl) begin
      decode = TGT_BUS_CTRL;
    end else if (h.irq) begin
      decode = TGT_IRQ;
    end else if (h.dram || h.memc_regs) begin
      decode = TGT_MEMC;
    end else if (h.dma_one || h.dma_two) begin
      decode = TGT_DMA;
    end else if (h.display) begin
      decode = TGT_DISPLAY;
    end else if (h.isa_io || h.isa_mem || h.isa_win_one || h.isa_win_two) begin
      decode = TGT_ISA;
    end else begin
      decode = TGT_BUS; // nothing owns it, so a bus cycle goes out
    end
  endfunction

  function automatic sel_s to_sel(input target_e t);
    to_sel = '0;
    unique case (t)
      TGT_ROM: to_sel.rom = 1'b1;
      TGT_BUS_CTRL: to_sel.bus_ctrl = 1'b1;
      TGT_IRQ: to_sel.irq = 1'b1;
      TGT_MEMC: to_sel.memc = 1'b1;
      TGT_DMA: to_sel.dma = 1'b1;
      TGT_DISPLAY: to_sel.display = 1'b1;
      TGT_ISA: to_sel.isa = 1'b1;
      TGT_NONE, TGT_BUS: to_sel = '0;
    endcase
  endfunction

  // core and other-master addresses go through the same map
  hit_s core_hit, ext_hit;
  target_e core_t, ext_t;
  assign core_hit = hits_of(core_req_i.addr);
  assign ext_hit = hits_of(ext_addr_i);
  assign core_t = decode(core_hit);
  assign ext_t = decode(ext_hit);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.start = 1'b0;
    d.sel = '0;
    d.target = TGT_NONE;
    if (core_req_i.valid) begin
      // every core request is taken and answered next cycle
      d.ack = 1'b1;
      d.target = core_t;
      d.addr = core_req_i.addr;
      d.write = core_req_i.write;
      d.wdata = core_req_i.wdata;
      d.rdata = 16'h0000;
      d.sel = to_sel(core_t);
      // rom goes out over the peripheral bus; module targets and unowned get a cycle
      d.start = (core_t != TGT_BUS_CTRL) && (core_t != TGT_IRQ);
      if (core_t == TGT_BUS_CTRL || core_t == TGT_IRQ) begin
        d.sel = '0; // served locally, claimed only for the core
      end
      if (core_t == TGT_BUS_CTRL) begin
        unique case (core_req_i.addr)
          ROM_BUS_CONTROL_ADDR: begin
            d.rdata = q.rom_ctl;
            if (core_req_i.write) begin
              d.rom_ctl = core_req_i.wdata & ROM_BUS_CONTROL_MASK;
            end
          end
          PERIPHERAL_CLOCK_GATE_ADDR: begin
            d.rdata = q.clk_gate;
            if (core_req_i.write) begin
              d.clk_gate = core_req_i.wdata & CLOCK_GATE_MASK;
            end
          end
          ROM_ACCESS_TIMING_ADDR: begin
            d.rdata = q.rom_tim;
            if (core_req_i.write) begin
              d.rom_tim = core_req_i.wdata & ROM_TIMING_MASK;
            end
          end
          REFRESH_CONTROL_ADDR: begin
            d.rdata = q.refresh;
            if (core_req_i.write) begin
              d.refresh = core_req_i.wdata;
            end
          end
          SILICON_REVISION_ADDR: d.rdata = REVISION;
          default: d.rdata = 16'h0000; // holes read zero, writes dropped
        endcase
      end
    end else if (ext_valid_i && ext_t != TGT_BUS) begin
      // another master: selects only, no local claim
      d.sel = to_sel(ext_t);
    end
    // power-domain loss: the four control registers return to their reset values
    if (hibernate_i) begin
      d.rom_ctl = ROM_BUS_CONTROL_RST;
      d.clk_gate = CLOCK_GATE_RST;
      d.rom_tim = ROM_TIMING_RST;
      d.refresh = REFRESH_RST;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // reset sync bits take constants only; the rest uses the released copy
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= rst_sync_d;
    end
  end

  always_ff @(posedge clock_i or negedge srst_n) begin
    if (!srst_n) begin
      q.ack <= 1'b0;
      q.rdata <= 16'h0000;
      q.target <= TGT_NONE;
      q.sel <= '0;
      q.start <= 1'b0;
      q.addr <= 32'h0000_0000;
      q.write <= 1'b0;
      q.wdata <= 16'h0000;
      q.rom_ctl <= ROM_BUS_CONTROL_RST;
      q.clk_gate <= CLOCK_GATE_RST;
      q.rom_tim <= ROM_TIMING_RST;
      q.refresh <= REFRESH_RST;
    end else begin
      q.ack <= d.ack;
      q.rdata <= d.rdata;
      q.target <= d.target;
      q.sel <= d.sel;
      q.start <= d.start;
      q.addr <= d.addr;
      q.write <= d.write;
      q.wdata <= d.wdata;
      q.rom_ctl <= d.rom_ctl;
      q.clk_gate <= d.clk_gate;
      q.rom_tim <= d.rom_tim;
      q.refresh <= d.refresh;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // core answer
  assign core_ack_o = q.ack;
  assign core_rdata_o = q.rdata;
  assign core_target_o = q.target;
  // internal peripheral bus: selects and start last one cycle, address and data held until the next core request
  assign sel_o = q.sel;
  assign bus_start_o = q.start;
  assign bus_addr_o = q.addr;
  assign bus_write_o = q.write;
  assign bus_wdata_o = q.wdata;
  // bit high passes the unit clock, low blocks it
  assign clk_enable_o = q.clk_gate[CLK_GATE_LSB +: CLK_GATE_W];
  assign rom_control_o = q.rom_ctl;
  assign rom_timing_o = q.rom_tim;
  assign refresh_control_o = q.refresh;

endmodule // host_bridge_address_decoder
`default_nettype wire

// File: bridge_assertions.sv
/* port checker for the host bridge decoder.
   assumes a bind from the bench top and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module bridge_assertions
  import bridge_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hibernate_i,
  // requests
  input wire req_s core_req_i,
  input wire logic ext_valid_i,
  input wire logic [31:0] ext_addr_i,
  // answers
  input wire logic core_ack_o,
  input wire target_e core_target_o,
  input wire sel_s sel_o,
  input wire logic bus_start_o,
  input wire logic [CLK_GATE_W-1:0] clk_enable_o,
  input wire logic [15:0] refresh_control_o
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // a core request landing inside one address range
  sequence s_hit(lo, hi);
    core_req_i.valid && core_req_i.addr >= lo && core_req_i.addr <= hi;
  endsequence
  a_ack_follows: assert property (core_req_i.valid |=> core_ack_o)
    else $error("no ack after request");
  a_ack_cause: assert property (core_ack_o |-> $past(core_req_i.valid))
    else $error("ack without request");
  a_rom_claim: assert property (s_hit(ROM_LO, ROM_HI) |=> core_target_o == TGT_ROM
    && sel_o.rom && bus_start_o) else $error("rom not claimed");
  a_ctrl_local: assert property (s_hit(BCR_LO, BCR_HI) |=> core_target_o == TGT_BUS_CTRL
    && sel_o == '0 && !bus_start_o) else $error("control access left the bridge");
  a_ext_select: assert property (!core_req_i.valid && ext_valid_i && ext_addr_i == IRQ_A0
    |=> sel_o.irq && !core_ack_o) else $error("no select for other master");
  a_bus_start: assert property (core_ack_o && core_target_o == TGT_BUS
    |-> bus_start_o && sel_o == '0) else $error("unowned access without bus cycle");
  a_dram_sel: assert property (s_hit(DRAM_LO, DRAM_HI) |=> sel_o.memc)
    else $error("dram not selected");
  a_isa_sel: assert property (s_hit(ISAMEM_LO, ISAIO_HI) |=> sel_o.isa)
    else $error("isa not selected");
  a_one_select: assert property ($onehot0(sel_o))
    else $error("several selects");
  a_hib_clear: assert property (hibernate_i |=> clk_enable_o == '0
    && refresh_control_o == '0) else $error("registers kept over hibernate");
endmodule // bridge_assertions
`default_nettype wire

// File: core_model.sv
/* processor core model issuing one request per falling edge.
   assumes the bench calls its tasks in order. */
`timescale 1ns/1ps
`default_nettype none
module core_model
  import bridge_pkg::*;
(
  // clock
  input wire logic clock_i,
  // request to the bridge
  output var req_s req_o
);
  initial req_o = '0;
  // held a full cycle across the sampling edge; back to back allowed
  task automatic issue(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(negedge clock_i);
    req_o <= '{valid: 1'b1, write: w, addr: a, wdata: d};
  endtask
  // payload inverted on release so a stale value is never mistaken
  task automatic idle();
    @(negedge clock_i);
    req_o <= '{1'b0, ~req_o.write, ~req_o.addr, ~req_o.wdata};
  endtask
endmodule // core_model
`default_nettype wire

// File: host_bridge_address_decoder_tb_top.sv
/* self-checking bench for the host bridge decoder.
   assumes the package constants and the core model beside it. */
`timescale 1ns/1ps
`default_nettype none
module host_bridge_address_decoder_tb_top;
  import bridge_pkg::*;
  typedef struct packed {
    target_e tgt;
    logic rd;
    logic [15:0] data;
    logic [31:0] addr;
    logic [15:0] wd;
  } exp_s;
  localparam logic [15:0] REV = 16'h0001; // arbitrary value
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hibernate_i = 1'b0;
  logic ext_valid_i = 1'b0;
  logic [31:0] ext_addr_i = 32'h0;
  req_s core_req;
  logic core_ack_o, bus_start_o, bus_write_o;
  logic [15:0] core_rdata_o, bus_wdata_o, rom_control_o, rom_timing_o, refresh_control_o;
  target_e core_target_o;
  sel_s sel_o;
  logic [31:0] bus_addr_o;
  logic [CLK_GATE_W-1:0] clk_enable_o;
  logic [15:0] s_ctl, s_gate, s_tim, s_ref;
  logic [31:0] edges [25] = '{ROM_LO, ROM_HI, IRQ_A0, IRQ_A1, IRQ_A2, IRQ_A3, IRQ_A4, IRQ_A5,
    DRAM_HI, MEMC_LO, MEMC_HI, DMA1_LO, DMA1_HI, DMA2_LO, DMA2_HI, DISP_LO, DISP_HI,
    ISAIO_LO, ISAIO_HI, ISAMEM_LO, ISAMEM_HI, ISAW1_LO, ISAW1_HI, ISAW2_LO, ISAW2_HI};
  exp_s q[$];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 clock_i = ~clock_i;
  core_model u_core (.clock_i(clock_i), .req_o(core_req));
  host_bridge_address_decoder #(.REVISION(REV)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hibernate_i(hibernate_i), .core_req_i(core_req),
    .core_ack_o(core_ack_o), .core_rdata_o(core_rdata_o), .core_target_o(core_target_o),
    .ext_valid_i(ext_valid_i), .ext_addr_i(ext_addr_i), .sel_o(sel_o),
    .bus_start_o(bus_start_o), .bus_addr_o(bus_addr_o), .bus_write_o(bus_write_o),
    .bus_wdata_o(bus_wdata_o), .clk_enable_o(clk_enable_o), .rom_control_o(rom_control_o),
    .rom_timing_o(rom_timing_o), .refresh_control_o(refresh_control_o));
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic clear_shadow();
    s_ctl = ROM_BUS_CONTROL_RST;
    s_gate = CLOCK_GATE_RST;
    s_tim = ROM_TIMING_RST;
    s_ref = REFRESH_RST;
  endtask
  function automatic target_e tgt_of(input logic [31:0] a);
    if (a inside {[ROM_LO:ROM_HI]}) return TGT_ROM;
    if (a inside {[BCR_LO:BCR_HI]}) return TGT_BUS_CTRL;
    if (a inside {IRQ_A0, IRQ_A1, IRQ_A2, IRQ_A3, IRQ_A4, IRQ_A5}) return TGT_IRQ;
    if (a inside {[DRAM_LO:DRAM_HI], [MEMC_LO:MEMC_HI]}) return TGT_MEMC;
    if (a inside {[DMA1_LO:DMA1_HI], [DMA2_LO:DMA2_HI]}) return TGT_DMA;
    if (a inside {[DISP_LO:DISP_HI]}) return TGT_DISPLAY;
    if (a inside {[ISAMEM_LO:ISAIO_HI], [ISAW1_LO:ISAW2_HI]}) return TGT_ISA;
    return TGT_BUS;
  endfunction
  // core accesses to owned registers stay local; module targets get one select
  function automatic sel_s sel_of(input target_e t);
    sel_of = '0;
    case (t)
      TGT_ROM: sel_of.rom = 1'b1;
      TGT_MEMC: sel_of.memc = 1'b1;
      TGT_DMA: sel_of.dma = 1'b1;
      TGT_DISPLAY: sel_of.display = 1'b1;
      TGT_ISA: sel_of.isa = 1'b1;
      default: sel_of = '0;
    endcase
  endfunction
  function automatic logic [15:0] rd_of(input logic [31:0] a);
    case (a)
      ROM_BUS_CONTROL_ADDR: return s_ctl;
      PERIPHERAL_CLOCK_GATE_ADDR: return s_gate;
      ROM_ACCESS_TIMING_ADDR: return s_tim;
      REFRESH_CONTROL_ADDR: return s_ref;
      SILICON_REVISION_ADDR: return REV;
      default: return 16'h0000;
    endcase
  endfunction
  // note the expectation first, then hand the request to the core model
  task automatic req(input logic w, input logic [31:0] a, input logic [15:0] d);
    q.push_back('{tgt_of(a), !w, rd_of(a), a, d});
    if (w && a == ROM_BUS_CONTROL_ADDR) s_ctl = d & ROM_BUS_CONTROL_MASK;
    if (w && a == PERIPHERAL_CLOCK_GATE_ADDR) s_gate = d & CLOCK_GATE_MASK;
    if (w && a == ROM_ACCESS_TIMING_ADDR) s_tim = d & ROM_TIMING_MASK;
    if (w && a == REFRESH_CONTROL_ADDR) s_ref = d;
    u_core.issue(w, a, d);
  endtask
  // results are settled by the falling edge; an ack with nothing noted is wrong
  always @(negedge clock_i) begin
    exp_s e;
    if (core_ack_o === 1'b1) begin
      check(q.size() != 0, 1'b1);
      e = (q.size() != 0) ? q.pop_front() : '0;
      check(core_target_o, e.tgt);
      check(bus_start_o, !(e.tgt inside {TGT_BUS_CTRL, TGT_IRQ}));
      check(sel_o, sel_of(e.tgt));
      check(bus_addr_o, e.addr);
      check(bus_write_o, !e.rd);
      check(bus_wdata_o, e.wd);
      if (e.rd) check(core_rdata_o, e.data);
    end
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    int unsigned i;
    i = $urandom(32'h9146a21d);
    clear_shadow();
    repeat (10) @(posedge clock_i);
    @(negedge clock_i) rst_n_i = 1'b1;
    repeat (3) @(posedge clock_i);
    check(rom_control_o, ROM_BUS_CONTROL_RST);
    check(rom_timing_o, ROM_TIMING_RST);
    check(refresh_control_o, REFRESH_RST);
    check(clk_enable_o, '0);
    for (i = 0; i < 7; i++) req(1'b0, BCR_LO + 4 * i, 16'h0);
    for (i = 0; i < 6; i++) req(1'b1, BCR_LO + 4 * i, 16'($urandom));
    for (i = 0; i < 7; i++) req(1'b0, BCR_LO + 4 * i, 16'h0);
    u_core.idle();
    repeat (2) @(negedge clock_i);
    check(clk_enable_o, s_gate[CLK_GATE_LSB +: CLK_GATE_W]);
    check(rom_control_o, s_ctl);
    check(rom_timing_o, s_tim);
    check(refresh_control_o, s_ref);
    foreach (edges[k]) begin
      req(1'b1, edges[k] - 1, 16'h5a5a);
      req(1'b0, edges[k], 16'h0);
      req(1'b0, edges[k] + 1, 16'h0);
    end
    repeat (40) req(1'($urandom), $urandom & 32'h1FFF_FFFF, 16'($urandom));
    u_core.idle();
    // other masters: selects only, never an ack
    @(negedge clock_i) ext_valid_i = 1'b1;
    ext_addr_i = IRQ_A0;
    @(negedge clock_i) check(sel_o, 32'h10);
    ext_addr_i = ROM_LO;
    @(negedge clock_i) check(sel_o, 32'h40);
    ext_valid_i = 1'b0;
    ext_addr_i = ~ROM_LO;
    req(1'b1, PERIPHERAL_CLOCK_GATE_ADDR, 16'h007E);
    req(1'b1, REFRESH_CONTROL_ADDR, 16'hFFFF);
    u_core.idle();
    @(negedge clock_i) hibernate_i = 1'b1;
    check(clk_enable_o, s_gate[CLK_GATE_LSB +: CLK_GATE_W]);
    check(refresh_control_o, s_ref);
    @(negedge clock_i) hibernate_i = 1'b0;
    clear_shadow();
    check(clk_enable_o, '0);
    check(rom_control_o, ROM_BUS_CONTROL_RST);
    check(rom_timing_o, ROM_TIMING_RST);
    check(refresh_control_o, REFRESH_RST);
    for (i = 0; i < 6; i++) req(1'b0, BCR_LO + 4 * i, 16'h0);
    u_core.idle();
    repeat (5) @(negedge clock_i);
    check(q.size(), 0);
    test_done();
  end
endmodule // host_bridge_address_decoder_tb_top
bind host_bridge_address_decoder bridge_assertions u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .hibernate_i(hibernate_i), .core_req_i(core_req_i),
  .ext_valid_i(ext_valid_i), .ext_addr_i(ext_addr_i), .core_ack_o(core_ack_o),
  .core_target_o(core_target_o), .sel_o(sel_o), .bus_start_o(bus_start_o),
  .clk_enable_o(clk_enable_o), .refresh_control_o(refresh_control_o));
`default_nettype wire
